/* hdl/tcq_consts.svh */
// Constants of the trace capture qualifier: register map, field positions, sizes.
// Assumes inclusion by bare name from the design files.
`ifndef TCQ_CONSTS_SVH
`define TCQ_CONSTS_SVH

// Register word addresses
`define TCQ_ADDR_W 4
`define TCQ_REG_CTRL 4'h0
`define TCQ_REG_CMD 4'h1
`define TCQ_REG_STATUS 4'h2
`define TCQ_REG_PTR 4'h3
`define TCQ_REG_RDIDX 4'h4
`define TCQ_REG_RDLO 4'h5
`define TCQ_REG_RDHI 4'h6
`define TCQ_REG_QBASE 4'h7
`define TCQ_QSTRIDE 4'h4

// Offsets inside one qualifier group
`define TCQ_Q_VLO 2'h0
`define TCQ_Q_VHI 2'h1
`define TCQ_Q_MLO 2'h2
`define TCQ_Q_MHI 2'h3

// Control field layout
`define TCQ_CTRL_W 8
`define TCQ_CTRL_RST 8'h00
`define TCQ_CMD_START 0
`define TCQ_CMD_STOP 1

// Sizes
`define TCQ_DEPTH 1000
`define TCQ_FRAME_W 42
`define TCQ_NQUAL 2
`define TCQ_LO_W 32

`endif

/* hdl/tcq_pkg.sv */
// Types shared by the trace capture qualifier files.
// Assumes tcq_consts.svh is on the include path.
`include "tcq_consts.svh"

package tcq_pkg;

   typedef struct packed {
      logic gate_latch;
      logic gate_and;
      logic gate_or;
      logic gate_en;
      logic start_mode;
      logic stop_mode;
      logic qual1_en;
      logic qual0_en;
   } tcq_ctrl_t;

   typedef struct packed {
      logic valid;
      logic [`TCQ_FRAME_W-1:0] data;
   } tcq_frame_t;

   typedef enum logic [0:0] {
      TCQ_IDLE = 1'b0,
      TCQ_RUN = 1'b1
   } tcq_state_t;

endpackage

/* hdl/tcq_qualifier.sv */
// Trace capture qualifier: decides per processor frame whether it enters the trace buffer.
// Assumes frames arrive on clk_i from same-clock logic, the gate line comes from a pin.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "tcq_consts.svh"

module tcq_qualifier #(
   parameter int DEPTH = `TCQ_DEPTH,
   parameter int FRAME_W = `TCQ_FRAME_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [`TCQ_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Emulation control
   input wire logic emu_start_i,
   input wire logic emu_stop_i,
   // Processor frame stream
   input wire tcq_pkg::tcq_frame_t frame_i,
   // External gate pin
   input wire logic ext_gate_in_i,
   // Status
   output logic qualifier_allows_capture_o,
   output logic ext_gate_allows_capture_o,
   output logic capture_o,
   output logic running_o
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   // Control and run state
   tcq_pkg::tcq_ctrl_t ctrl_ff;
   tcq_pkg::tcq_ctrl_t nxt_ctrl;
   tcq_pkg::tcq_ctrl_t wctrl;
   tcq_pkg::tcq_state_t state_ff;
   tcq_pkg::tcq_state_t nxt_state;

   // Trigger and buffer state
   logic qa_ff;
   logic nxt_qa;
   logic done_ff;
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] cnt_ff;
   logic wrapped_ff;
   logic cap_ff;
   logic [AW-1:0] rdidx_ff;
   logic [31:0] rdata_ff;
   logic [FRAME_W-1:0] mem_rdata;

   // Gate conditioning
   logic gsync1_ff;
   logic gsync2_ff;
   logic gprev_ff;
   logic glatch_ff;
   logic gallow_ff;

   // Qualifier registers
   logic [FRAME_W-1:0] qval_ff [`TCQ_NQUAL];
   logic [FRAME_W-1:0] qmsk_ff [`TCQ_NQUAL];
   logic [`TCQ_NQUAL-1:0] qhit;

   // Bus decode
   wire wr_ctrl = wr_i && (addr_i == `TCQ_REG_CTRL);
   wire wr_cmd = wr_i && (addr_i == `TCQ_REG_CMD);
   wire wr_rdidx = wr_i && (addr_i == `TCQ_REG_RDIDX);
   wire start_req = emu_start_i || (wr_cmd && wdata_i[`TCQ_CMD_START]);
   wire stop_req = emu_stop_i || (wr_cmd && wdata_i[`TCQ_CMD_STOP]);

   // Frames only count while emulation runs; one strobe per sampling point
   wire running = (state_ff == tcq_pkg::TCQ_RUN);
   wire frame_ev = frame_i.valid && running;

   // Per-qualifier compare and register write ports
   genvar k;
   generate
      for (k = 0; k < `TCQ_NQUAL; k++) begin : g_qual
         localparam logic [`TCQ_ADDR_W-1:0] QB =
            `TCQ_ADDR_W'(`TCQ_REG_QBASE + k * `TCQ_QSTRIDE);
         // Groups do not sit on four-word boundaries, so decode by distance from the base
         wire [`TCQ_ADDR_W-1:0] rel = addr_i - QB;
         wire in_grp = (addr_i >= QB) && (rel < `TCQ_QSTRIDE);
         wire sel = wr_i && in_grp;
         wire [1:0] off = rel[1:0];
         // Each qualifier matches on its own, independent of the other
         assign qhit[k] = ((frame_i.data ^ qval_ff[k]) & qmsk_ff[k]) == '0;
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               qval_ff[k] <= '0;
               qmsk_ff[k] <= '0;
            end else if (sel) begin
               unique case (off)
                  `TCQ_Q_VLO: qval_ff[k][`TCQ_LO_W-1:0] <= wdata_i;
                  `TCQ_Q_VHI: qval_ff[k][FRAME_W-1:`TCQ_LO_W] <=
                     wdata_i[FRAME_W-`TCQ_LO_W-1:0];
                  `TCQ_Q_MLO: qmsk_ff[k][`TCQ_LO_W-1:0] <= wdata_i;
                  `TCQ_Q_MHI: qmsk_ff[k][FRAME_W-`TCQ_LO_W-1+`TCQ_LO_W:`TCQ_LO_W] <=
                     wdata_i[FRAME_W-`TCQ_LO_W-1:0];
               endcase
            end
         end
      end
   endgenerate

   // Disabled qualifiers are masked off before any trigger logic sees them
   wire qmatch = (ctrl_ff.qual0_en && qhit[0]) || (ctrl_ff.qual1_en && qhit[1]);
   wire qual_on = ctrl_ff.qual0_en || ctrl_ff.qual1_en;
   wire stop_on = qual_on && ctrl_ff.stop_mode;
   wire start_on = qual_on && ctrl_ff.start_mode;
   wire use_or = ctrl_ff.gate_en && ctrl_ff.gate_or;
   wire use_and = ctrl_ff.gate_en && ctrl_ff.gate_and;

   // Capture decision for the current frame
   wire gate_only = ctrl_ff.gate_en && !qual_on;
   wire cap_and = qa_ff && gallow_ff;
   // OR goes through the conditioned gate, so a latched fall closes this path too
   wire cap_or = qa_ff || gallow_ff;
   wire cap_qual = use_and ? cap_and : (use_or ? cap_or : qa_ff);
   wire cap_sel = !qual_on ? (gate_only ? gallow_ff : 1'b1) : cap_qual;
   wire capture = frame_ev && cap_sel;

   // Start mode counts frames that the qualifier actually let through
   wire start_cnt = frame_ev && start_on && qa_ff && (!use_and || gallow_ff);
   wire cnt_full = (cnt_ff == LAST);
   wire [AW-1:0] nxt_cnt = cnt_full ? '0 : cnt_ff + 1'b1;
   // One shot per run: after the bufferful the trigger stays quiet until the next start
   wire start_end = start_cnt && cnt_full;
   wire start_hit = qmatch && !qa_ff && !done_ff;

   // Control write: a request naming both trigger modes or both combines keeps the old pair
   always_comb begin
      wctrl = tcq_pkg::tcq_ctrl_t'(wdata_i[`TCQ_CTRL_W-1:0]);
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = wctrl;
         if (wctrl.stop_mode && wctrl.start_mode) begin
            nxt_ctrl.stop_mode = ctrl_ff.stop_mode;
            nxt_ctrl.start_mode = ctrl_ff.start_mode;
         end
         if (wctrl.gate_or && wctrl.gate_and) begin
            nxt_ctrl.gate_or = ctrl_ff.gate_or;
            nxt_ctrl.gate_and = ctrl_ff.gate_and;
         end
      end
   end

   // Run state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         tcq_pkg::TCQ_IDLE: if (start_req) nxt_state = tcq_pkg::TCQ_RUN;
         tcq_pkg::TCQ_RUN: if (stop_req && !start_req) nxt_state = tcq_pkg::TCQ_IDLE;
      endcase
   end

   // Qualifier allow flag
   always_comb begin
      nxt_qa = qa_ff;
      if (start_req) begin
         nxt_qa = stop_on;
      end else if (frame_ev) begin
         if (stop_on) begin
            if (qmatch) nxt_qa = 1'b0;
         end else if (start_on) begin
            if (start_end) begin
               nxt_qa = 1'b0;
            end else if (start_hit) begin
               nxt_qa = 1'b1;
            end
         end else begin
            nxt_qa = qmatch;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= tcq_pkg::tcq_ctrl_t'(`TCQ_CTRL_RST);
         state_ff <= tcq_pkg::TCQ_IDLE;
         qa_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         state_ff <= nxt_state;
         qa_ff <= nxt_qa;
      end
   end

   // Start-mode bufferful counter, one shot per run
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || start_req) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end else if (start_cnt) begin
         cnt_ff <= nxt_cnt;
         if (cnt_full) begin
            done_ff <= 1'b1;
         end
      end
   end

   // Pointer wrap: the oldest slot is overwritten first
   wire wptr_last = (wptr_ff == LAST);
   wire [AW-1:0] nxt_wptr = wptr_last ? '0 : wptr_ff + 1'b1;

   // Circular write pointer; the buffer always keeps the newest frames
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wptr_ff <= '0;
         wrapped_ff <= 1'b0;
         cap_ff <= 1'b0;
      end else begin
         cap_ff <= capture;
         if (start_req) begin
            wptr_ff <= '0;
            wrapped_ff <= 1'b0;
         end else if (capture) begin
            wptr_ff <= nxt_wptr;
            if (wptr_last) begin
               wrapped_ff <= 1'b1;
            end
         end
      end
   end

   // Gate pin: two flip-flops before any logic reads the line; idle level is high
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gsync1_ff <= 1'b1;
         gsync2_ff <= 1'b1;
      end else begin
         gsync1_ff <= ext_gate_in_i;
         gsync2_ff <= gsync1_ff;
      end
   end

   // Edge detect on the settled copy; a line already low at start is not an edge
   wire gfall = gprev_ff && !gsync2_ff;
   // Latch mode drops the allow on the edge itself, a cycle before the latch shows it
   wire gallow_latch = gsync2_ff && !glatch_ff && !gfall;
   wire nxt_gallow = ctrl_ff.gate_latch ? gallow_latch : gsync2_ff;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gprev_ff <= 1'b1;
         glatch_ff <= 1'b0;
         gallow_ff <= 1'b1;
      end else begin
         gprev_ff <= gsync2_ff;
         // An edge in the same cycle as a start still latches: the set wins
         if (gfall && ctrl_ff.gate_latch) begin
            glatch_ff <= 1'b1;
         end else if (start_req) begin
            glatch_ff <= 1'b0;
         end
         gallow_ff <= nxt_gallow;
      end
   end

   // Read index and registered read data
   wire [5:0] status_bits = {gsync2_ff, wrapped_ff, done_ff, gallow_ff, qa_ff, running};
   wire [31:0] status_word = {26'h0, status_bits};
   wire [31:0] ptr_word = {wrapped_ff, 5'h0, 10'(cnt_ff), 6'h0, 10'(wptr_ff)};
   // Read address decode
   wire rsel_ctrl = (addr_i == `TCQ_REG_CTRL);
   wire rsel_status = (addr_i == `TCQ_REG_STATUS);
   wire rsel_ptr = (addr_i == `TCQ_REG_PTR);
   wire rsel_rdidx = (addr_i == `TCQ_REG_RDIDX);
   wire rsel_rdlo = (addr_i == `TCQ_REG_RDLO);
   wire rsel_rdhi = (addr_i == `TCQ_REG_RDHI);
   wire [31:0] rdidx_word = 32'(rdidx_ff);
   wire [31:0] rdhi_word = 32'(mem_rdata[FRAME_W-1:`TCQ_LO_W]);
   wire [31:0] rd_mux =
      rsel_ctrl ? {24'h0, ctrl_ff} :
      rsel_status ? status_word :
      rsel_ptr ? ptr_word :
      rsel_rdidx ? rdidx_word :
      rsel_rdlo ? mem_rdata[`TCQ_LO_W-1:0] :
      rsel_rdhi ? rdhi_word :
      32'h0;

   // Read data are zero outside the answer cycle, so an OR of several slaves stays clean
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdidx_ff <= '0;
         rdata_ff <= 32'h0;
      end else begin
         if (wr_rdidx) begin
            rdidx_ff <= AW'(wdata_i);
         end
         rdata_ff <= rd_i ? rd_mux : 32'h0;
      end
   end

   // Buffer reads trail an index write by two cycles: one for the index, one for the memory
   tcq_trace_mem #(
      .WIDTH(FRAME_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .clk_i(clk_i),
      .we_i(capture),
      .waddr_i(wptr_ff),
      .wdata_i(frame_i.data),
      .raddr_i(rdidx_ff),
      .rdata_o(mem_rdata)
   );

   assign rdata_o = rdata_ff;
   assign qualifier_allows_capture_o = qa_ff;
   assign ext_gate_allows_capture_o = gallow_ff;
   assign capture_o = cap_ff;
   assign running_o = running;

endmodule

/* hdl/tcq_trace_mem.sv */
// Trace buffer memory: one write port, one read port with registered data.
// Assumes a single clock; read data follow the read index one cycle later.
`timescale 1ns/100ps

module tcq_trace_mem #(
   parameter int WIDTH = 42,
   parameter int DEPTH = 1000,
   parameter int AW = 10
) (
   // Clock
   input wire logic clk_i,
   // Write side
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   // Read side
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end

endmodule

/* verification/tcq_frame_src.sv */
// Behavioural frame source and gate line driver for the processor side.
// Assumes one clock shared with the qualifier; frame data count up from reset.
`timescale 1ns/100ps

module tcq_frame_src (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bench control
   input wire logic en_i,
   input wire logic slow_i,
   input wire logic gate_i,
   // Far side pins
   output tcq_pkg::tcq_frame_t frame_o,
   output logic gate_o
);
   logic [41:0] cnt = 42'h0;
   logic tog = 1'b0;
   logic fire;
   initial frame_o = '0;
   initial gate_o = 1'b1;
   // Slow mode leaves a gap after every frame to stress the stream timing
   assign fire = en_i && !(slow_i && tog);
   always @(posedge clk_i) begin
      tog <= en_i && !tog;
      gate_o <= gate_i;
      frame_o.valid <= rst_n_i && fire;
      frame_o.data <= fire ? cnt : ~frame_o.data;
      cnt <= !rst_n_i ? 42'h0 : cnt + {41'h0, fire};
   end
endmodule

/* verification/tcq_qualifier_asserts.sv */
// Port checker for the trace capture qualifier.
// Assumes one clock domain; mirrors the control register from bus writes.
`timescale 1ns/100ps
`include "tcq_consts.svh"

module tcq_qualifier_asserts (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register writes
   input wire logic [`TCQ_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   // Stream, gate and status
   input wire logic emu_start_i,
   input wire tcq_pkg::tcq_frame_t frame_i,
   input wire logic ext_gate_in_i,
   input wire logic qualifier_allows_capture_o,
   input wire logic ext_gate_allows_capture_o,
   input wire logic capture_o,
   input wire logic running_o
);
   logic [7:0] ctl_ff;
   logic qen, plain, gor, gand, fr;
   // Refused mode writes are skipped whole; the bench keeps other bits equal then
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctl_ff <= 8'h00;
      end else if (wr_i && addr_i == `TCQ_REG_CTRL && !(&wdata_i[3:2]) && !(&wdata_i[6:5])) begin
         ctl_ff <= wdata_i[7:0];
      end
   end
   assign qen = |ctl_ff[1:0];
   assign plain = qen && !(|ctl_ff[3:2]);
   assign gor = ctl_ff[4] && ctl_ff[5];
   assign gand = ctl_ff[4] && ctl_ff[6];
   assign fr = frame_i.valid && running_o;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_reset_state: assert property ($rose(rst_n_i) |-> !running_o && !capture_o &&
      !qualifier_allows_capture_o && ext_gate_allows_capture_o) else $error("bad reset state");
   a_free_run: assert property (ctl_ff == 8'h00 && fr |=> capture_o)
      else $error("frame missed with no factors");
   a_plain_qual: assert property (plain && !gor && fr |=>
      capture_o == $past(qualifier_allows_capture_o && (!gand || ext_gate_allows_capture_o)))
      else $error("plain qualifier capture wrong");
   a_gate_only: assert property (!qen && ctl_ff[4] && fr |=>
      capture_o == $past(ext_gate_allows_capture_o)) else $error("gate only capture wrong");
   a_stop_arm: assert property ($past(emu_start_i) && qen && ctl_ff[2] |->
      qualifier_allows_capture_o) else $error("stop mode not armed");
   a_start_arm: assert property ($past(emu_start_i) && qen && ctl_ff[3] |->
      !qualifier_allows_capture_o) else $error("start mode armed early");
   a_stop_halt: assert property (qen && ctl_ff[2] && !gor && !qualifier_allows_capture_o
      && fr |=> !capture_o) else $error("capture after stop match");
   a_stop_gated: assert property (qen && ctl_ff[2] && gand && qualifier_allows_capture_o && fr
      |=> capture_o == $past(ext_gate_allows_capture_o)) else $error("stop and gate wrong");
   a_level_gate: assert property (ctl_ff[4] && !ctl_ff[7] && $changed(ext_gate_in_i) |->
      ##3 ext_gate_allows_capture_o == $past(ext_gate_in_i, 3)) else $error("level gate lag");
   a_latch_hold: assert property (ctl_ff[4] && ctl_ff[7] && !ext_gate_allows_capture_o &&
      !emu_start_i && !$past(emu_start_i) |=> !ext_gate_allows_capture_o)
      else $error("latched gate reopened");
   a_capture_cause: assert property (capture_o |-> $past(fr))
      else $error("capture without frame");
endmodule

bind tcq_qualifier tcq_qualifier_asserts u_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
   .emu_start_i, .frame_i, .ext_gate_in_i, .qualifier_allows_capture_o,
   .ext_gate_allows_capture_o, .capture_o, .running_o);

/* verification/tcq_qualifier_tb.sv */
// Self-checking bench for the trace capture qualifier.
// Assumes the frame source model and a buffer depth cut to 8 for short runs.
`timescale 1ns/100ps
`include "tcq_consts.svh"

module tcq_qualifier_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o, ncap = 32'h0;
   logic wr_i = 1'b0, rd_i = 1'b0, emu_start_i = 1'b0, emu_stop_i = 1'b0;
   logic en = 1'b0, slow = 1'b0, gate = 1'b1;
   logic ext_gate_in_i, qa, ga, capture_o, running_o;
   tcq_pkg::tcq_frame_t frame_i;
   int errors = 0, cmp_count = 0;

   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (capture_o === 1'b1) ncap <= ncap + 32'h1;

   tcq_qualifier #(.DEPTH(8)) uut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .emu_start_i, .emu_stop_i, .frame_i, .ext_gate_in_i, .qualifier_allows_capture_o(qa),
      .ext_gate_allows_capture_o(ga), .capture_o, .running_o);
   tcq_frame_src src (.clk_i, .rst_n_i, .en_i(en), .slow_i(slow), .gate_i(gate),
      .frame_o(frame_i), .gate_o(ext_gate_in_i));

   task automatic wrap_up;
      $display("Compares %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
      cmp_count++;
      if (got !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] m, e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(nm, e, rdata_o & m);
   endtask
   // One run: set flags and gate, start, optional low gate pulse, n frames, count captures
   task automatic scen(input logic [7:0] c, input logic g, p, s, input int n, input int e);
      wr(`TCQ_REG_CTRL, {24'h0, c});
      gate <= g;
      cyc(6);
      emu_start_i <= 1'b1;
      cyc(1);
      emu_start_i <= 1'b0;
      if (p) begin
         gate <= 1'b0;
         cyc(3);
         gate <= 1'b1;
      end
      cyc(6);
      ncap <= 32'h0;
      slow <= s;
      en <= 1'b1;
      cyc(s ? 2 * n : n);
      en <= 1'b0;
      cyc(4);
      chk("captures", e, ncap);
      emu_stop_i <= 1'b1;
      cyc(1);
      emu_stop_i <= 1'b0;
   endtask

   // Whole run is under 800 cycles; the limit leaves ample margin
   initial begin
      cyc(20000);
      errors++;
      wrap_up;
   end

   initial begin
      cyc(12);
      rst_n_i <= 1'b1;
      rd("ctrl", `TCQ_REG_CTRL, 32'hff, 32'h0);
      rd("unmapped", 4'hf, 32'hffffffff, 32'h0);
      scen(8'h00, 1, 0, 1, 24, 24);
      rd("ptr", `TCQ_REG_PTR, 32'h800003ff, 32'h80000000);
      wr(`TCQ_REG_RDIDX, 32'h7);
      rd("slot", `TCQ_REG_RDLO, 32'hffffffff, 32'h17);
      rd("status", `TCQ_REG_STATUS, 32'h1, 32'h0);
      // Qualifiers match frames whose count ends in 1 (zero) or 5 (one) modulo 8
      for (int q = 0; q < 2; q++) begin
         wr(4'(`TCQ_REG_QBASE + q * `TCQ_QSTRIDE), q ? 32'h5 : 32'h1);
         wr(4'(`TCQ_REG_QBASE + q * `TCQ_QSTRIDE + `TCQ_Q_MLO), 32'h7);
      end
      scen(8'h01, 1, 0, 0, 16, 2);
      scen(8'h02, 1, 0, 0, 16, 2);
      scen(8'h03, 1, 0, 0, 16, 4);
      scen(8'h52, 0, 0, 0, 16, 0);
      scen(8'h52, 1, 0, 0, 16, 2);
      scen(8'h10, 0, 0, 0, 16, 0);
      scen(8'h10, 1, 1, 0, 16, 16);
      scen(8'h90, 1, 1, 0, 16, 0);
      scen(8'h06, 1, 0, 0, 16, 6);
      scen(8'h36, 1, 0, 0, 16, 16);
      scen(8'h56, 1, 0, 0, 16, 6);
      scen(8'h56, 0, 0, 0, 16, 0);
      scen(8'h0a, 1, 0, 1, 24, 8);
      scen(8'h3a, 1, 0, 0, 24, 24);
      scen(8'h3a, 0, 0, 0, 24, 8);
      scen(8'h5a, 1, 0, 0, 24, 8);
      scen(8'h5a, 0, 0, 0, 24, 0);
      wr(`TCQ_REG_CTRL, 32'h06);
      wr(`TCQ_REG_CTRL, 32'h0e);
      rd("modes", `TCQ_REG_CTRL, 32'hff, 32'h06);
      wrap_up;
   end
endmodule
